// ===== src/shadow_cache_pkg.sv
// Package with register map, field layout and decode types for the shadow/cache configuration bank
package shadow_cache_pkg;
    // Register offsets
    localparam logic [7:0] OFF_SHADOW_LOW  = 8'h26;
    localparam logic [7:0] OFF_PROTECT_MAP = 8'h27;
    localparam logic [7:0] OFF_CACHE_CTRL  = 8'h28;
    localparam logic [7:0] OFF_UPPER_BOUND = 8'h29;
    // Reset values
    localparam logic [7:0] RST_SHADOW_LOW  = 8'h00;
    localparam logic [7:0] RST_PROTECT_MAP = 8'h00;
    localparam logic [7:0] RST_CACHE_CTRL  = 8'h08;
    localparam logic [3:0] RST_BOUND_RSVD  = 4'hA;
    localparam logic [3:0] RST_BOUND_LIMIT = 4'h0;
    // Cache control field positions
    localparam int CC_ENABLE   = 7;
    localparam int CC_DRAM_PERF = 6;
    localparam int CC_ALL_NC   = 5;
    localparam int CC_LOW_NC   = 4;
    localparam int CC_TIME_HI  = 3;
    localparam int CC_TIME_LO  = 2;
    localparam int CC_SIZE_HI  = 1;
    localparam int CC_SIZE_LO  = 0;
    // Address layout of the 24-bit memory bus
    localparam int ADDR_W      = 24;
    localparam int MB_HI       = 23;
    localparam int MB_LO       = 20;
    localparam int SEG_HI      = 19;
    localparam int SEG_LO      = 16;
    localparam int BLK_HI      = 15;
    localparam int BLK_LO      = 14;
    // Segment numbers within the first megabyte
    localparam logic [3:0] SEG_C     = 4'hC;
    localparam logic [3:0] SEG_A     = 4'hA;
    localparam logic [3:0] MB_ZERO   = 4'h0;
    // Cache write-hit timing codes
    typedef enum logic [1:0] {
        TIME_INVALID = 2'h0,
        TIME_ZERO_WS = 2'h1,
        TIME_ONE_WS  = 2'h2,
        TIME_ZERO_EX = 2'h3
    } hit_timing_t;
    // Memory access request
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } mem_req_t;
    // Decoded access attributes
    typedef struct packed {
        logic              use_dram;
        logic              write_block;
        logic              cacheable;
        logic              remapped;
        logic [ADDR_W-1:0] dram_addr;
    } mem_attr_t;
    // Cache settings as seen by the cache machinery
    typedef struct packed {
        logic        enable;
        logic        dram_perf;
        hit_timing_t timing;
        logic [1:0]  size;
        logic        zero_wait;
        logic        extend_strobe;
    } cache_cfg_t;
endpackage

// ===== src/shadow_cache_decode.sv
// Combinational decoder mapping a memory access onto shadow, protect, remap and cacheability attributes
`timescale 1ns/10ps
`default_nettype none
module shadow_cache_decode
    import shadow_cache_pkg::*;
(
    input  wire shadow_cache_pkg::mem_req_t  req,          // Access under decode
    input  wire logic [7:0]                  shadow_low,   // Low-ROM shadow enables
    input  wire logic [7:0]                  protect_map,  // Protect and remap setting
    input  wire logic [7:0]                  cache_ctrl,   // Cache control setting
    input  wire logic [3:0]                  bound,        // Cacheable upper bound
    output var shadow_cache_pkg::mem_attr_t  attr          // Decoded attributes
);
    import shadow_cache_pkg::*;

    // Address slices
    wire logic [3:0] mb_field   = req.addr[MB_HI:MB_LO];        // Megabyte number
    wire logic [3:0] seg_field  = req.addr[SEG_HI:SEG_LO];      // 64KB segment in first MB
    wire logic [1:0] blk_field  = req.addr[BLK_HI:BLK_LO];      // 16KB block in a segment
    wire logic       first_mb   = (mb_field == MB_ZERO);        // Inside first megabyte
    wire logic       in_c_seg   = first_mb && (seg_field == SEG_C); // Low-ROM area
    wire logic       in_upper   = first_mb && (seg_field >= SEG_C); // C..F segments
    wire logic       in_low_hole = first_mb && (seg_field >= SEG_A); // 640KB to 1MB
    wire logic [1:0] prot_idx   = 2'(seg_field - SEG_C);        // Protect bit index

    // Shadow enables per 16KB block: read bits upper nibble, write bits lower
    wire logic shadow_rd = in_c_seg && shadow_low[4 + blk_field];
    wire logic shadow_wr = in_c_seg && shadow_low[blk_field];
    wire logic protected_seg = in_upper && protect_map[4 + prot_idx];

    // Remap: accesses into the first MB block of the remap window when enabled
    wire logic [3:0] remap_mb = protect_map[3:0];
    wire logic       remap_on = (remap_mb != MB_ZERO);

    // Cacheability
    wire logic [3:0] bound_mb = bound;
    wire logic below_bound = (bound_mb == MB_ZERO) || (mb_field < bound_mb);
    wire logic size_fits   = (mb_field >> 1) < (4'h1 << cache_ctrl[CC_SIZE_HI:CC_SIZE_LO]);

    always_comb begin
        // Reads served from DRAM when shadow read is set, outside the C..F segments always DRAM
        attr.use_dram    = req.write ? shadow_wr : (in_c_seg ? shadow_rd : !in_upper);
        attr.write_block = req.write && (protected_seg || (in_c_seg && !shadow_wr));
        attr.cacheable   = cache_ctrl[CC_ENABLE] && !cache_ctrl[CC_ALL_NC]
                           && !(cache_ctrl[CC_LOW_NC] && in_low_hole)
                           && below_bound && size_fits;
        attr.remapped    = remap_on && in_low_hole && !in_upper;
        attr.dram_addr   = attr.remapped ? {remap_mb, req.addr[SEG_HI:0]} : req.addr;
    end
endmodule
`default_nettype wire

// ===== src/shadow_cache_config_regs.sv
// Register bank holding shadow, write-protect, remap and cache settings of the system controller
`timescale 1ns/10ps
`default_nettype none
module shadow_cache_config_regs
    import shadow_cache_pkg::*;
(
    input  wire logic                        clock,       // 100 MHz controller clock
    input  wire logic                        rst_n,       // Async reset, active low
    input  wire logic                        clk_en,      // Freezes all state when low
    input  wire logic [7:0]                  reg_addr,    // Register index
    input  wire logic [7:0]                  reg_wdata,   // Write data
    input  wire logic                        reg_write,   // Write strobe
    input  wire logic                        reg_read,    // Read strobe
    output logic [7:0]                       reg_rdata,   // Read data, cycle after strobe
    input  wire shadow_cache_pkg::mem_req_t  mem_req,     // Memory access to classify
    output var shadow_cache_pkg::mem_attr_t  mem_attr,    // Registered access attributes
    output var shadow_cache_pkg::cache_cfg_t cache_cfg    // Registered cache settings
);
    import shadow_cache_pkg::*;

    // Stored registers
    logic [7:0] shadow_low;     // Low-ROM shadow enables
    logic [7:0] protect_map;    // Write protect and remap
    logic [7:0] cache_ctrl;     // Cache control
    logic [3:0] bound_limit;    // Cacheable upper bound

    // Address decode
    wire logic hit_shadow  = (reg_addr == OFF_SHADOW_LOW);
    wire logic hit_protect = (reg_addr == OFF_PROTECT_MAP);
    wire logic hit_cache   = (reg_addr == OFF_CACHE_CTRL);
    wire logic hit_bound   = (reg_addr == OFF_UPPER_BOUND);

    // Read multiplexer, unmapped reads return zero
    wire logic [7:0] read_mux =
        hit_shadow  ? shadow_low  :
        hit_protect ? protect_map :
        hit_cache   ? cache_ctrl  :
        hit_bound   ? {RST_BOUND_RSVD, bound_limit} : 8'h00;

    // Decoded attributes before the output register
    mem_attr_t next_attr;

    // Timing code drives the cache strobe shaping
    wire hit_timing_t timing = hit_timing_t'(cache_ctrl[CC_TIME_HI:CC_TIME_LO]);
    cache_cfg_t next_cfg;
    always_comb begin
        next_cfg.enable        = cache_ctrl[CC_ENABLE];
        next_cfg.dram_perf     = cache_ctrl[CC_DRAM_PERF];   // Software keeps cache off first
        next_cfg.timing        = timing;
        next_cfg.size          = cache_ctrl[CC_SIZE_HI:CC_SIZE_LO];
        next_cfg.zero_wait     = (timing == TIME_ZERO_WS) || (timing == TIME_ZERO_EX);
        next_cfg.extend_strobe = (timing == TIME_ZERO_EX);
    end

    // Access decoder
    shadow_cache_decode u_decode (
        .req         (mem_req),
        .shadow_low  (shadow_low),
        .protect_map (protect_map),
        .cache_ctrl  (cache_ctrl),
        .bound       (bound_limit),
        .attr        (next_attr)
    );

    // Register writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shadow_low  <= RST_SHADOW_LOW;
            protect_map <= RST_PROTECT_MAP;
            cache_ctrl  <= RST_CACHE_CTRL;
            bound_limit <= RST_BOUND_LIMIT;
        end else if (clk_en && reg_write) begin
            if (hit_shadow)  shadow_low  <= reg_wdata;
            if (hit_protect) protect_map <= reg_wdata;
            if (hit_cache)   cache_ctrl  <= reg_wdata;
            if (hit_bound)   bound_limit <= reg_wdata[3:0];
        end
    end

    // Read data register, holds only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= reg_read ? read_mux : 8'h00;
        end
    end

    // Attribute and configuration registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_attr  <= '0;
            cache_cfg <= '0;
        end else if (clk_en) begin
            mem_attr  <= mem_req.valid ? next_attr : '0;
            cache_cfg <= next_cfg;
        end
    end

    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    reserved_nibble_a: assert property (reg_read && hit_bound && clk_en |=> reg_rdata[7:4] == RST_BOUND_RSVD)
        else $error("reserved bound bits not 1010");
    all_noncache_a: assert property (clk_en && cache_ctrl[CC_ALL_NC] |=> !mem_attr.cacheable)
        else $error("access cacheable with all non-cacheable set");
    cache_off_a: assert property (clk_en && !cache_ctrl[CC_ENABLE] |=> !mem_attr.cacheable)
        else $error("access cacheable with cache off");
    low_hole_a: assert property (clk_en && mem_req.valid && cache_ctrl[CC_LOW_NC]
        && mem_req.addr[MB_HI:MB_LO] == MB_ZERO && mem_req.addr[SEG_HI:SEG_LO] >= SEG_A
        |=> !mem_attr.cacheable)
        else $error("640KB-1MB access cacheable");
    protect_block_a: assert property (clk_en && mem_req.valid && mem_req.write
        && mem_req.addr[MB_HI:SEG_LO] == {MB_ZERO, 4'hF} && protect_map[7]
        |=> mem_attr.write_block)
        else $error("write to protected segment not blocked");
    shadow_read_a: assert property (clk_en && mem_req.valid && !mem_req.write
        && mem_req.addr[MB_HI:SEG_LO] == {MB_ZERO, SEG_C} && shadow_low[4 + mem_req.addr[BLK_HI:BLK_LO]]
        |=> mem_attr.use_dram)
        else $error("shadow read not served from DRAM");
    shadow_write_a: assert property (clk_en && mem_req.valid && mem_req.write
        && mem_req.addr[MB_HI:SEG_LO] == {MB_ZERO, SEG_C} && !shadow_low[mem_req.addr[BLK_HI:BLK_LO]]
        |=> !mem_attr.use_dram)
        else $error("disabled shadow write reached DRAM");
    bound_limit_a: assert property (clk_en && mem_req.valid && bound_limit != MB_ZERO
        && mem_req.addr[MB_HI:MB_LO] >= bound_limit |=> !mem_attr.cacheable)
        else $error("access above bound cacheable");
    extend_strobe_a: assert property (clk_en && cache_ctrl[CC_TIME_HI:CC_TIME_LO] == 2'h3
        |=> cache_cfg.extend_strobe && cache_cfg.zero_wait)
        else $error("timing 11 not decoded");
    remap_write_a: assert property (clk_en && reg_write && hit_protect |=> protect_map == $past(reg_wdata))
        else $error("protect register not written");
endmodule
`default_nettype wire

// ===== testbench/cpu_cycle_model.sv
// Processor-side model that issues single memory cycles to be classified
`timescale 1ns/10ps
`default_nettype none
module cpu_cycle_model
    import shadow_cache_pkg::*;
(
    input  wire logic                  clock,   // Controller clock
    input  wire logic                  rst_n,   // Async reset, active low
    input  wire logic                  start,   // Issue one cycle
    input  wire logic                  write,   // Cycle is a write
    input  wire logic [23:0]           addr,    // Cycle address
    output var shadow_cache_pkg::mem_req_t mem_req // Request to the block
);
    // One-cycle request; idle lines invert every cycle, so a stale value comes back every second idle cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= '0;
        end else if (start) begin
            mem_req <= {1'b1, write, addr};
        end else begin
            mem_req <= {1'b0, ~mem_req.write, ~mem_req.addr};
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_shadow_cache_config_regs.sv
// Self-checking bench for the shadow and cache configuration registers
`timescale 1ns/10ps
`default_nettype none
module tb_shadow_cache_config_regs;
    import shadow_cache_pkg::*;
    logic        clock, rst_n, clk_en, reg_write, reg_read, start, write; // Bench drives
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;                           // Register bus
    logic [23:0] addr;                                                     // Cycle address
    logic [1:0]  t, s;                                                     // Timing and size codes
    mem_req_t    mem_req;                                                  // Model request
    mem_attr_t   mem_attr;                                                 // Decoded attributes
    cache_cfg_t  cache_cfg;                                                // Cache settings
    int          errors, checks_done;                                      // Counters
    localparam logic [27:0] M_DRAM = 28'h8000000, M_BLK = 28'h4000000, M_CACHE = 28'h2000000;

    shadow_cache_config_regs DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mem_req(mem_req), .mem_attr(mem_attr), .cache_cfg(cache_cfg));
    cpu_cycle_model cpu (.clock(clock), .rst_n(rst_n), .start(start), .write(write), .addr(addr),
        .mem_req(mem_req));

    // Byte comparison
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Attribute comparison under a mask
    task automatic cmp_attr(input logic [27:0] got, input logic [27:0] exp, input logic [27:0] mask);
        checks_done++;
        if ((got & mask) !== (exp & mask)) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // One-cycle read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 cmp_reg(reg_rdata, exp);
    endtask
    // One memory cycle through the model, attributes checked one cycle later
    task automatic mem(input logic w, input logic [23:0] a, input logic [27:0] exp, input logic [27:0] mask);
        @(posedge clock);
        start <= 1'b1;
        write <= w;
        addr  <= a;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        #1 cmp_attr(mem_attr, exp, mask);
    endtask
    // Counts and verdict
    task automatic conclude;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Watchdog against a hang
    initial begin
        #200000;
        errors++;
        conclude();
    end
    // Test sequence
    initial begin
        {reg_write, reg_read, start, write, reg_addr, reg_wdata, addr} = '0;
        {rst_n, clk_en, errors, checks_done} = '0;
        clk_en = 1'b1;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1 cmp_reg(cache_cfg, 8'h20);
        rd(OFF_SHADOW_LOW, 8'h00);
        rd(OFF_PROTECT_MAP, 8'h00);
        rd(OFF_CACHE_CTRL, 8'h08);
        rd(OFF_UPPER_BOUND, 8'hA0);
        $display("test reset values done");
        wr(OFF_SHADOW_LOW, 8'h5A);
        rd(OFF_SHADOW_LOW, 8'h5A);
        wr(OFF_PROTECT_MAP, 8'hA5);
        rd(OFF_PROTECT_MAP, 8'hA5);
        wr(OFF_UPPER_BOUND, 8'hFF);
        rd(OFF_UPPER_BOUND, 8'hAF);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        @(posedge clock);
        clk_en <= 1'b0;
        wr(OFF_SHADOW_LOW, 8'h3C);
        clk_en <= 1'b1;
        rd(OFF_SHADOW_LOW, 8'h5A);
        $display("test access done");
        // Timing codes paired with a suitable cache size, then the rest
        for (int i = 0; i < 6; i++) begin
            t = (i < 4) ? ((i < 2) ? 2'h1 : 2'h3) : ((i == 4) ? 2'h0 : 2'h2);
            s = i[1:0];
            wr(OFF_CACHE_CTRL, {4'h8, t, s});
            @(posedge clock);
            #1 cmp_reg(cache_cfg, {2'b10, t, s, t[0], t == 2'h3});
            rd(OFF_CACHE_CTRL, {4'h8, t, s});
        end
        wr(OFF_CACHE_CTRL, 8'h48);
        @(posedge clock);
        #1 cmp_reg(cache_cfg, 8'h60);
        $display("test cache settings done");
        wr(OFF_PROTECT_MAP, 8'h00);
        wr(OFF_SHADOW_LOW, 8'h20);
        mem(1'b0, 24'h0C4000, M_DRAM, M_DRAM);
        mem(1'b0, 24'h0C0000, 28'h0, M_DRAM);
        wr(OFF_SHADOW_LOW, 8'h04);
        mem(1'b1, 24'h0C8000, M_DRAM, M_DRAM | M_BLK);
        mem(1'b1, 24'h0CC000, M_BLK, M_DRAM | M_BLK);
        wr(OFF_PROTECT_MAP, 8'h10);
        mem(1'b1, 24'h0C8000, M_BLK, M_BLK);
        wr(OFF_PROTECT_MAP, 8'h03);
        mem(1'b0, 24'h0A0000, 28'h13A0000, 28'h1FFFFFF);
        wr(OFF_PROTECT_MAP, 8'h00);
        mem(1'b0, 24'h0A0000, 28'h0, 28'h1000000);
        $display("test shadow and remap done");
        wr(OFF_UPPER_BOUND, 8'h00);
        wr(OFF_CACHE_CTRL, 8'h8B);
        mem(1'b0, 24'h100000, M_CACHE, M_CACHE);
        wr(OFF_CACHE_CTRL, 8'hAB);
        mem(1'b0, 24'h100000, 28'h0, M_CACHE);
        wr(OFF_CACHE_CTRL, 8'h9B);
        mem(1'b0, 24'h0A0000, 28'h0, M_CACHE);
        mem(1'b0, 24'h090000, M_CACHE, M_CACHE);
        wr(OFF_CACHE_CTRL, 8'h8B);
        wr(OFF_UPPER_BOUND, 8'h02);
        mem(1'b0, 24'h200000, 28'h0, M_CACHE);
        mem(1'b0, 24'h100000, M_CACHE, M_CACHE);
        wr(OFF_UPPER_BOUND, 8'h00);
        wr(OFF_CACHE_CTRL, 8'h88);
        mem(1'b0, 24'h100000, M_CACHE, M_CACHE);
        mem(1'b0, 24'h200000, 28'h0, M_CACHE);
        wr(OFF_CACHE_CTRL, 8'h0B);
        mem(1'b0, 24'h100000, 28'h0, M_CACHE);
        $display("test cacheability done");
        conclude();
    end
endmodule
`default_nettype wire
